//--- design/dam_channel.sv
// one alarm channel: threshold or rate-of-change comparison
`timescale 1ns/1ps
module dam_channel #(
   parameter int DATA_W = 14,
   parameter int WIN_W  = 8
) (
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              update,
   input  wire logic              restart,
   input  wire logic              enable,
   input  wire logic              roc_mode,
   input  wire logic              above,
   input  wire logic              is_signed,
   input  wire logic [DATA_W-1:0] value,
   input  wire logic [DATA_W-1:0] limit,
   input  wire logic [WIN_W-1:0]  window,
   output logic                   active_q
);
   import dam_pkg::*;

   localparam int EXT_W = DATA_W + 2;
   localparam int PRD_W = EXT_W + WIN_W + 2;

   // widen a sample as signed or straight binary
   function automatic logic signed [EXT_W-1:0] widen(
      input logic [DATA_W-1:0] v,
      input logic              sgn
   );
      widen = sgn ? {{2{v[DATA_W-1]}}, v} : {2'b00, v};
   endfunction : widen

   logic signed [EXT_W-1:0] val_s;
   logic signed [EXT_W-1:0] lim_s;
   logic signed [EXT_W-1:0] base_q;
   logic signed [EXT_W-1:0] delta;
   logic signed [PRD_W-1:0] delta_x;
   logic signed [PRD_W-1:0] lim_x;
   logic [WIN_W-1:0]        win_eff;
   logic [WIN_W-1:0]        cnt_q;
   logic                    thr_hit;
   logic                    roc_hit;
   logic                    win_done;

   // comparison terms
   assign val_s    = widen(value, is_signed);
   assign lim_s    = widen(limit, is_signed);
   assign win_eff  = (window == '0) ? WIN_W'(1) : window;
   assign delta    = EXT_W'(val_s - base_q);
   assign delta_x  = PRD_W'(delta);
   // widen both factors first so the product cannot wrap at the sample width
   assign lim_x    = PRD_W'(lim_s) * PRD_W'($signed({1'b0, win_eff}));
   assign thr_hit  = above ? (val_s > lim_s) : (val_s < lim_s);
   // change over the window against limit scaled by the window: average vs limit
   assign roc_hit  = above ? (delta_x > lim_x) : (delta_x < lim_x);
   assign win_done = (cnt_q >= win_eff);

   // window counter and start sample
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q  <= '0;
         base_q <= '0;
      end
      else if (restart || !enable || !roc_mode)
      begin
         cnt_q  <= '0;
         base_q <= '0;
      end
      else if (update)
      begin
         if (cnt_q == '0 || win_done)
         begin
            base_q <= val_s;
            cnt_q  <= WIN_W'(1);
         end
         else
            cnt_q <= WIN_W'(cnt_q + 1'b1);
      end
   end

   // alarm condition, evaluated on each data update in threshold mode, only at each window end in rate mode
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         active_q <= 1'b0;
      else if (restart || !enable)
         active_q <= 1'b0;
      else if (update && !roc_mode)
         active_q <= thr_hit;
      else if (update && cnt_q != '0 && win_done)
         active_q <= roc_hit;
   end

endmodule : dam_channel

//--- design/dam_pkg.sv
// shared constants and types of the dual alarm monitor
package dam_pkg;

   // ==============================
   // register offsets (byte address of the low byte)
   localparam logic [5:0] OFS_ALARM1_MAGNITUDE   = 6'h20;
   localparam logic [5:0] OFS_ALARM2_MAGNITUDE   = 6'h22;
   localparam logic [5:0] OFS_ALARM1_RATE_WINDOW = 6'h24;
   localparam logic [5:0] OFS_ALARM2_RATE_WINDOW = 6'h26;
   localparam logic [5:0] OFS_ALARM_CONTROL      = 6'h28;

   // ==============================
   // reset values
   localparam logic [15:0] RST_MAGNITUDE = 16'h0000;
   localparam logic [7:0]  RST_WINDOW    = 8'h00;
   localparam logic [15:0] RST_CONTROL   = 16'h0000;

   // ==============================
   // field positions
   localparam int MAG_ABOVE_BIT  = 15;
   localparam int MAG_LIMIT_MSB  = 13;
   localparam int WIN_MSB        = 7;
   localparam int CTL_ROC2_BIT   = 15;
   localparam int CTL_SRC2_LSB   = 12;
   localparam int CTL_ROC1_BIT   = 11;
   localparam int CTL_SRC1_LSB   = 8;
   localparam int CTL_FILT2_BIT  = 5;
   localparam int CTL_FILT1_BIT  = 4;
   localparam int CTL_PIN_EN_BIT = 2;
   localparam int CTL_POL_BIT    = 1;
   localparam int CTL_LINE_BIT   = 0;
   localparam int SRC_W          = 3;

   // ==============================
   // source select codes
   localparam logic [2:0] SRC_OFF     = 3'h0;
   localparam logic [2:0] SRC_SUPPLY  = 3'h1;
   localparam logic [2:0] SRC_AUX     = 3'h4;
   localparam logic [2:0] SRC_TEMP    = 3'h5;
   localparam logic [2:0] SRC_FULL    = 3'h6;
   localparam logic [2:0] SRC_SIGNED  = 3'h7;

   // ==============================
   // one set of measurement outputs, 14 bits each
   typedef struct packed {
      logic [13:0] supply;
      logic [13:0] aux_adc;
      logic [13:0] temperature;
      logic [13:0] full_circle_tilt_output;
      logic [13:0] signed_tilt_output;
   } dam_meas_t;

   // register contents, also the nonvolatile image
   typedef struct packed {
      logic [15:0] alarm1_magnitude;
      logic [15:0] alarm2_magnitude;
      logic [7:0]  alarm1_rate_window;
      logic [7:0]  alarm2_rate_window;
      logic [15:0] alarm_control;
   } dam_regs_t;

   localparam dam_regs_t RST_REGS = '{
      alarm1_magnitude:   RST_MAGNITUDE,
      alarm2_magnitude:   RST_MAGNITUDE,
      alarm1_rate_window: RST_WINDOW,
      alarm2_rate_window: RST_WINDOW,
      alarm_control:      RST_CONTROL
   };

endpackage : dam_pkg

//--- design/dam_top.sv
// dual alarm monitor: registers, source selection and alarm pin drive
`timescale 1ns/1ps
module dam_top #(
   parameter int DATA_W = 14,
   parameter int WIN_W  = 8
) (
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic [5:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_rd,
   output logic [15:0]            reg_rdata_q,
   output logic                   reg_rvalid_q,
   input  wire logic              sample_update,
   input  wire dam_pkg::dam_meas_t meas_raw,
   input  wire dam_pkg::dam_meas_t meas_filtered,
   input  wire dam_pkg::dam_regs_t nv_image_in,
   input  wire logic              nv_image_valid,
   output dam_pkg::dam_regs_t     regs_q,
   input  wire logic [1:0]        misc_claim,
   input  wire logic [1:0]        misc_level,
   input  wire logic [1:0]        gpio_dir_out,
   input  wire logic [1:0]        gpio_level,
   input  wire logic [1:0]        dio_in,
   output logic [1:0]             dio_out_q,
   output logic [1:0]             dio_oe_n_q,
   output logic [1:0]             gpio_in_q,
   output logic                   alarm1_active_q,
   output logic                   alarm2_active_q
);
   import dam_pkg::*;

   // ==============================
   // register decode
   logic                   load_pend_q;
   logic                   wr_ok;
   logic                   wr_mag1;
   logic                   wr_mag2;
   logic                   wr_win1;
   logic                   wr_win2;
   logic                   wr_ctl;
   logic [15:0]            rd_word;
   dam_regs_t              regs_d;

   assign wr_ok   = reg_wr && !load_pend_q;
   assign wr_mag1 = wr_ok && (reg_addr == OFS_ALARM1_MAGNITUDE);
   assign wr_mag2 = wr_ok && (reg_addr == OFS_ALARM2_MAGNITUDE);
   assign wr_win1 = wr_ok && (reg_addr == OFS_ALARM1_RATE_WINDOW);
   assign wr_win2 = wr_ok && (reg_addr == OFS_ALARM2_RATE_WINDOW);
   assign wr_ctl  = wr_ok && (reg_addr == OFS_ALARM_CONTROL);

   // next register contents
   always_comb
   begin
      regs_d = regs_q;
      if (wr_mag1)
         regs_d.alarm1_magnitude = reg_wdata;
      if (wr_mag2)
         regs_d.alarm2_magnitude = reg_wdata;
      if (wr_win1)
         regs_d.alarm1_rate_window = reg_wdata[WIN_MSB:0];
      if (wr_win2)
         regs_d.alarm2_rate_window = reg_wdata[WIN_MSB:0];
      if (wr_ctl)
         regs_d.alarm_control = reg_wdata;
   end

   // read mux, upper window bits and unmapped offsets read zero
   assign rd_word =
      (reg_addr == OFS_ALARM1_MAGNITUDE)   ? regs_q.alarm1_magnitude :
      (reg_addr == OFS_ALARM2_MAGNITUDE)   ? regs_q.alarm2_magnitude :
      (reg_addr == OFS_ALARM1_RATE_WINDOW) ? {8'h00, regs_q.alarm1_rate_window} :
      (reg_addr == OFS_ALARM2_RATE_WINDOW) ? {8'h00, regs_q.alarm2_rate_window} :
      (reg_addr == OFS_ALARM_CONTROL)      ? regs_q.alarm_control :
      16'h0000;

   // ==============================
   // register storage, restored from the nonvolatile image after reset
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         regs_q      <= RST_REGS;
         load_pend_q <= 1'b1;
      end
      else if (load_pend_q)
      begin
         if (nv_image_valid)
            regs_q <= nv_image_in;
         load_pend_q <= 1'b0;
      end
      else
         regs_q <= regs_d;
   end

   // read answer one edge after the strobe
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reg_rdata_q  <= 16'h0000;
         reg_rvalid_q <= 1'b0;
      end
      else
      begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd)
            reg_rdata_q <= rd_word;
      end
   end

   // ==============================
   // control fields
   logic [SRC_W-1:0] src1;
   logic [SRC_W-1:0] src2;
   logic             roc1;
   logic             roc2;
   logic             filt1;
   logic             filt2;
   logic             pin_en;
   logic             pin_pol;
   logic             pin_line;

   assign src1     = regs_q.alarm_control[CTL_SRC1_LSB +: SRC_W];
   assign src2     = regs_q.alarm_control[CTL_SRC2_LSB +: SRC_W];
   assign roc1     = regs_q.alarm_control[CTL_ROC1_BIT];
   assign roc2     = regs_q.alarm_control[CTL_ROC2_BIT];
   assign filt1    = regs_q.alarm_control[CTL_FILT1_BIT];
   assign filt2    = regs_q.alarm_control[CTL_FILT2_BIT];
   assign pin_en   = regs_q.alarm_control[CTL_PIN_EN_BIT];
   assign pin_pol  = regs_q.alarm_control[CTL_POL_BIT];
   assign pin_line = regs_q.alarm_control[CTL_LINE_BIT];

   // ==============================
   // source selection
   // pick one output of a measurement set; off or unused gives zero
   function automatic logic [DATA_W-1:0] pick(
      input dam_meas_t    m,
      input logic [SRC_W-1:0] s
   );
      case (s)
         SRC_SUPPLY: pick = m.supply;
         SRC_AUX:    pick = m.aux_adc;
         SRC_TEMP:   pick = m.temperature;
         SRC_FULL:   pick = m.full_circle_tilt_output;
         SRC_SIGNED: pick = m.signed_tilt_output;
         default:    pick = '0;
      endcase
   endfunction : pick

   // valid source codes enable the alarm
   function automatic logic src_valid(input logic [SRC_W-1:0] s);
      src_valid = (s == SRC_SUPPLY) || (s == SRC_AUX) || (s == SRC_TEMP) ||
                  (s == SRC_FULL) || (s == SRC_SIGNED);
   endfunction : src_valid

   // tilt outputs are twos complement, the others straight binary
   function automatic logic src_signed(input logic [SRC_W-1:0] s);
      src_signed = (s == SRC_FULL) || (s == SRC_SIGNED);
   endfunction : src_signed

   logic [DATA_W-1:0] val1;
   logic [DATA_W-1:0] val2;
   logic              restart1;
   logic              restart2;

   assign val1 = filt1 ? pick(meas_filtered, src1) : pick(meas_raw, src1);
   assign val2 = filt2 ? pick(meas_filtered, src2) : pick(meas_raw, src2);
   // any reconfiguration restarts the channel's window
   assign restart1 = wr_mag1 || wr_win1 || wr_ctl || load_pend_q;
   assign restart2 = wr_mag2 || wr_win2 || wr_ctl || load_pend_q;

   // ==============================
   // the two alarm channels
   dam_channel #(
      .DATA_W (DATA_W),
      .WIN_W  (WIN_W)
   ) u_alarm1 (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .update    (sample_update),
      .restart   (restart1),
      .enable    (src_valid(src1)),
      .roc_mode  (roc1),
      .above     (regs_q.alarm1_magnitude[MAG_ABOVE_BIT]),
      .is_signed (src_signed(src1)),
      .value     (val1),
      .limit     (regs_q.alarm1_magnitude[MAG_LIMIT_MSB:0]),
      .window    (regs_q.alarm1_rate_window),
      .active_q  (alarm1_active_q)
   );

   dam_channel #(
      .DATA_W (DATA_W),
      .WIN_W  (WIN_W)
   ) u_alarm2 (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .update    (sample_update),
      .restart   (restart2),
      .enable    (src_valid(src2)),
      .roc_mode  (roc2),
      .above     (regs_q.alarm2_magnitude[MAG_ABOVE_BIT]),
      .is_signed (src_signed(src2)),
      .value     (val2),
      .limit     (regs_q.alarm2_magnitude[MAG_LIMIT_MSB:0]),
      .window    (regs_q.alarm2_rate_window),
      .active_q  (alarm2_active_q)
   );

   // ==============================
   // alarm pin and I/O line ownership
   logic       alarm_any;
   logic       alarm_level;
   logic [1:0] alm_claim;
   logic [1:0] dio_out_d;
   logic [1:0] dio_oe_n_d;

   assign alarm_any   = alarm1_active_q || alarm2_active_q;
   assign alarm_level = pin_pol ? alarm_any : !alarm_any;
   assign alm_claim   = pin_en ? (pin_line ? 2'b10 : 2'b01) : 2'b00;

   // per line: misc first, then alarm, then general I/O, else released
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (misc_claim[i])
         begin
            dio_out_d[i]  = misc_level[i];
            dio_oe_n_d[i] = 1'b0;
         end
         else if (alm_claim[i])
         begin
            dio_out_d[i]  = alarm_level;
            dio_oe_n_d[i] = 1'b0;
         end
         else if (gpio_dir_out[i])
         begin
            dio_out_d[i]  = gpio_level[i];
            dio_oe_n_d[i] = 1'b0;
         end
         else
         begin
            dio_out_d[i]  = 1'b0;
            dio_oe_n_d[i] = 1'b1;
         end
      end
   end

   // registered pin drive and input capture
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dio_out_q  <= 2'b00;
         dio_oe_n_q <= 2'b11;
         gpio_in_q  <= 2'b00;
      end
      else
      begin
         dio_out_q  <= dio_out_d;
         dio_oe_n_q <= dio_oe_n_d;
         gpio_in_q  <= dio_in;
      end
   end

endmodule : dam_top

//--- dv/dam_pin_model.sv
// pin side of the two i/o lines: pull-ups feed the pin inputs
`timescale 1ns/1ps
module dam_pin_model (
   input  wire logic [1:0] dio_out_q,
   input  wire logic [1:0] dio_oe_n_q,
   output logic [1:0]      dio_in
);
   // a released line floats high, a driven one shows the output
   assign dio_in = (dio_out_q & ~dio_oe_n_q) | dio_oe_n_q;
endmodule : dam_pin_model

//--- dv/dam_props.sv
// assertions on the ports of the dual alarm monitor
`timescale 1ns/1ps
module dam_props (
   input wire logic              mclk,
   input wire logic              reset_n,
   input wire logic [5:0]        reg_addr,
   input wire logic              reg_rd,
   input wire logic [15:0]       reg_rdata_q,
   input wire logic              reg_rvalid_q,
   input wire logic              sample_update,
   input wire dam_pkg::dam_regs_t regs_q,
   input wire logic [1:0]        misc_claim,
   input wire logic [1:0]        misc_level,
   input wire logic [1:0]        gpio_dir_out,
   input wire logic [1:0]        dio_out_q,
   input wire logic [1:0]        dio_oe_n_q,
   input wire logic              alarm1_active_q,
   input wire logic              alarm2_active_q
);
   import dam_pkg::*;
   // ==============================
   // helper decode
   wire [15:0] ctl    = regs_q.alarm_control;
   wire        any_al = alarm1_active_q | alarm2_active_q;
   wire        lvl    = ctl[1] ? any_al : ~any_al; // pin level per polarity
   wire        mapped = reg_addr >= 6'h20 && reg_addr <= 6'h28 && !reg_addr[0];
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ==============================
   // register port
   chk_rvalid_follows_rd: assert property (reg_rd |=> reg_rvalid_q)
      else $error("read answer missing");
   chk_rvalid_only_rd: assert property (reg_rvalid_q |-> $past(reg_rd))
      else $error("read answer without read");
   chk_unmapped_read_zero: assert property (reg_rd && !mapped |=> reg_rdata_q == 16'h0000)
      else $error("unmapped read not zero");
   // ==============================
   // alarm status
   chk_src1_off_quiet: assert property (
      ctl[10:8] inside {3'h0, 3'h2, 3'h3} |-> !alarm1_active_q)
      else $error("alarm 1 active while disabled");
   chk_src2_off_quiet: assert property (
      ctl[14:12] inside {3'h0, 3'h2, 3'h3} |-> !alarm2_active_q)
      else $error("alarm 2 active while disabled");
   chk_alarm1_on_sample: assert property (
      $rose(alarm1_active_q) |-> $past(sample_update))
      else $error("alarm 1 rose without data update");
   chk_alarm2_on_sample: assert property (
      $rose(alarm2_active_q) |-> $past(sample_update))
      else $error("alarm 2 rose without data update");
   // ==============================
   // pin drive
   chk_misc_pin_wins: assert property (
      misc_claim[0] |=> !dio_oe_n_q[0] && dio_out_q[0] == $past(misc_level[0]))
      else $error("misc control lost line 0");
   chk_alarm_pin_level: assert property (
      !misc_claim[0] && ctl[2] && !ctl[0] |=> !dio_oe_n_q[0] && dio_out_q[0] == $past(lvl))
      else $error("alarm level wrong on line 0");
   chk_line1_released: assert property (
      !misc_claim[1] && !gpio_dir_out[1] && !(ctl[2] && ctl[0]) |=> dio_oe_n_q[1])
      else $error("line 1 driven while unclaimed");
   cover property (alarm1_active_q && ctl[11]);
   cover property (reg_rd && !mapped);
   cover property (!dio_oe_n_q[1] && ctl[2] && ctl[0]);
endmodule : dam_props

//--- dv/tb.sv
// self-checking bench of the dual alarm monitor
`timescale 1ns/1ps
module tb;
   import dam_pkg::*;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic [5:0]  reg_addr = 6'h00;
   logic        reg_wr = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata_q;
   logic        reg_rvalid_q;
   logic        sample_update = 1'b0;
   dam_meas_t   meas_raw = '0;
   dam_meas_t   meas_filtered = '0;
   dam_regs_t   nv_image_in = '0;
   logic        nv_image_valid = 1'b0;
   dam_regs_t   regs_q;
   logic [1:0]  misc_claim = 2'h0;
   logic [1:0]  misc_level = 2'h0;
   logic [1:0]  gpio_dir_out = 2'h0;
   logic [1:0]  gpio_level = 2'h0;
   logic [1:0]  dio_in;
   logic [1:0]  dio_out_q;
   logic [1:0]  dio_oe_n_q;
   logic [1:0]  gpio_in_q;
   logic        alarm1_active_q;
   logic        alarm2_active_q;
   logic        on;
   int          miscompares = 0;
   int          n_tests = 0;
   int          cycles = 0;
   // ==============================
   // clock, design and pin model
   always #50 mclk = ~mclk;
   dam_top uut (.mclk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_q,
      .reg_rvalid_q, .sample_update, .meas_raw, .meas_filtered, .nv_image_in,
      .nv_image_valid, .regs_q, .misc_claim, .misc_level, .gpio_dir_out, .gpio_level,
      .dio_in, .dio_out_q, .dio_oe_n_q, .gpio_in_q, .alarm1_active_q, .alarm2_active_q);
   dam_pin_model u_pins (.dio_out_q, .dio_oe_n_q, .dio_in);
   // ==============================
   // tasks
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask : cmp16
   task automatic cmp1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask : cmp1
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      cmp1(reg_rvalid_q, 1'b1);
      cmp16(reg_rdata_q, e);
   endtask : rd
   task automatic smp(input logic [13:0] r, input logic [13:0] f);
      @(negedge mclk);
      meas_raw = {5{r}};
      meas_filtered = {5{f}};
      sample_update = 1'b1;
      @(negedge mclk);
      sample_update = 1'b0;
   endtask : smp
   task automatic al(input logic e1, input logic e2);
      cmp1(alarm1_active_q, e1);
      cmp1(alarm2_active_q, e2);
   endtask : al
   task automatic rst;
      @(negedge mclk);
      reset_n = 1'b0;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
   endtask : rst
   // timeout guard
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         stop_test;
      end
   end
   // ==============================
   // test sequence
   initial
   begin
      rst;
      for (int a = 32; a <= 42; a += 2)
         rd(6'(a), 16'h0000); // reset values and unmapped hole
      $display("test reset values done");
      wr(OFS_ALARM1_RATE_WINDOW, 16'hff05);
      rd(OFS_ALARM1_RATE_WINDOW, 16'h0005);
      wr(OFS_ALARM2_RATE_WINDOW, 16'h1203);
      rd(OFS_ALARM2_RATE_WINDOW, 16'h0003);
      $display("test windows done");
      wr(OFS_ALARM2_MAGNITUDE, 16'hc010);
      rd(OFS_ALARM2_MAGNITUDE, 16'hc010);
      wr(OFS_ALARM_CONTROL, 16'h1000);
      smp(14'h0011, 14'h0000);
      al(1'b0, 1'b1);
      smp(14'h0010, 14'h0000);
      al(1'b0, 1'b0);
      wr(OFS_ALARM2_MAGNITUDE, 16'h0010);
      smp(14'h000f, 14'h0000);
      al(1'b0, 1'b1);
      wr(OFS_ALARM2_MAGNITUDE, 16'hbff0);
      wr(OFS_ALARM_CONTROL, 16'h7000);
      smp(14'h0001, 14'h0000);
      al(1'b0, 1'b1);
      $display("test threshold done");
      wr(OFS_ALARM1_MAGNITUDE, 16'h8000);
      wr(OFS_ALARM2_MAGNITUDE, 16'h8000);
      for (int c = 0; c < 8; c++)
      begin
         wr(OFS_ALARM_CONTROL, {1'b0, 3'(c), 1'b0, 3'(c), 8'h00});
         smp(14'h0005, 14'h0005);
         on = (c == 1 || c > 3);
         al(on, on);
      end
      wr(OFS_ALARM_CONTROL, 16'h1110);
      smp(14'h0000, 14'h0005);
      al(1'b1, 1'b0);
      wr(OFS_ALARM_CONTROL, 16'h1120);
      smp(14'h0000, 14'h0005);
      al(1'b0, 1'b1);
      wr(OFS_ALARM1_MAGNITUDE, 16'h0006);
      smp(14'h0005, 14'h0005);
      al(1'b1, 1'b1);
      $display("test sources done");
      wr(OFS_ALARM1_MAGNITUDE, 16'h8003);
      wr(OFS_ALARM1_RATE_WINDOW, 16'h0002);
      wr(OFS_ALARM_CONTROL, 16'h1900);
      smp(14'd100, 14'd0);
      al(1'b0, 1'b1);
      smp(14'd103, 14'd0);
      al(1'b0, 1'b1);
      smp(14'd107, 14'd0);
      al(1'b1, 1'b1);
      smp(14'd110, 14'd0);
      al(1'b1, 1'b1);
      smp(14'd113, 14'd0);
      al(1'b0, 1'b1);
      wr(OFS_ALARM_CONTROL, 16'h9100);
      for (int v = 200; v < 203; v++)
      begin
         smp(14'(v), 14'd0);
         al(1'b1, 1'b0);
      end
      smp(14'd203, 14'd0);
      al(1'b1, 1'b1);
      $display("test rate mode done");
      for (int p = 0; p < 2; p++)
         for (int l = 0; l < 2; l++)
         begin
            wr(OFS_ALARM_CONTROL, 16'h1104 | 16'(p * 2 + l));
            smp(14'h0005, 14'h0005);
            al(1'b1, 1'b1);
            @(negedge mclk);
            cmp1(dio_in[l], 1'(p));
            cmp1(dio_in[1 - l], 1'b1);
         end
      misc_claim = 2'b01;
      gpio_dir_out = 2'b10;
      repeat (2) @(negedge mclk);
      cmp1(dio_in[0], 1'b0);
      cmp1(dio_in[1], 1'b1);
      cmp1(gpio_in_q[0], 1'b0);
      cmp1(gpio_in_q[1], 1'b1);
      wr(OFS_ALARM_CONTROL, 16'h1103);
      @(negedge mclk);
      cmp1(dio_in[1], 1'b0);
      misc_claim = 2'b00;
      $display("test pin drive done");
      nv_image_in = '{16'h8123, 16'h0456, 8'h07, 8'h09, 16'h1234};
      nv_image_valid = 1'b1;
      rst;
      rd(OFS_ALARM1_MAGNITUDE, 16'h8123);
      rd(OFS_ALARM2_MAGNITUDE, 16'h0456);
      rd(OFS_ALARM1_RATE_WINDOW, 16'h0007);
      rd(OFS_ALARM2_RATE_WINDOW, 16'h0009);
      rd(OFS_ALARM_CONTROL, 16'h1234);
      $display("test image restore done");
      stop_test;
   end
endmodule : tb
bind dam_top dam_props u_props (.mclk, .reset_n, .reg_addr, .reg_rd, .reg_rdata_q,
   .reg_rvalid_q, .sample_update, .regs_q, .misc_claim, .misc_level, .gpio_dir_out,
   .dio_out_q, .dio_oe_n_q, .alarm1_active_q, .alarm2_active_q);
